// file: inc/tic_pkg.sv
package tic_pkg;

	localparam int TIC_CHANNELS = 5;
	localparam int TIC_GR_WIDTH = 16;
	localparam int TIC_ADR_WIDTH = 8;

	// Byte offsets inside one channel's 32-byte window; address bits 7..5
	// pick the channel.
	localparam logic [4:0] OFF_IO_SEL = 5'h00;
	localparam logic [4:0] OFF_FLAGS  = 5'h04;
	localparam logic [4:0] OFF_IRQ_EN = 5'h08;
	localparam logic [4:0] OFF_GEN_A  = 5'h0c;
	localparam logic [4:0] OFF_GEN_B  = 5'h10;

	// Field positions.
	localparam int IO_B_LSB  = 4;
	localparam int IO_A_LSB  = 0;
	localparam int FLAG_WRAP = 2;
	localparam int FLAG_B    = 1;
	localparam int FLAG_A    = 0;

	// Reset values; these also hold the bits that always read as one.
	localparam logic [7:0] IO_SEL_RESET = 8'h08;
	localparam logic [7:0] FLAGS_RESET  = 8'h78;
	localparam logic [7:0] IRQ_EN_RESET = 8'h78;

	localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
	localparam logic [15:0] CNT_ZERO     = 16'h0000;

	// Compare codes when the function field top bit is zero.
	localparam logic [1:0] OUT_NONE   = 2'h0;
	localparam logic [1:0] OUT_LOW    = 2'h1;
	localparam logic [1:0] OUT_HIGH   = 2'h2;
	localparam logic [1:0] OUT_TOGGLE = 2'h3;
	// Capture codes when the function field top bit is one.
	localparam logic [1:0] CAP_RISE = 2'h0;
	localparam logic [1:0] CAP_FALL = 2'h1;
	localparam logic [1:0] CAP_BOTH = 2'h2;
	localparam logic [1:0] CAP_NONE = 2'h3;

	// Combined mode codes of channels 3 and 4.
	localparam logic [1:0] CMD_COMPLEMENTARY = 2'h2;
	localparam logic [1:0] CMD_RESET_SYNC    = 2'h3;

	localparam int CH_NO_TOGGLE = 2;
	localparam int CH_PHASE     = 2;
	localparam int CH_PWM_LO    = 3;
	localparam int CH_PWM_HI    = 4;
	localparam int CH_DMA_LAST  = 3;

	typedef struct packed {
		logic       hit;
		logic       capture;
		logic       pin;
	} tic_gr_result_type;

	typedef struct packed {
		logic [2:0]  fieldB;
		logic [2:0]  fieldA;
		logic [2:0]  flags;
		logic [2:0]  armed;
		logic [2:0]  irqEn;
		logic [15:0] genA;
		logic [15:0] genB;
		logic        pinA;
		logic        pinB;
		logic        eqA;
		logic        eqB;
		logic [2:0]  syncA;
		logic [2:0]  syncB;
	} tic_chan_type;

endpackage

// file: core/tic_timer_io_control.sv
`timescale 1ns/1ps
module tic_timer_io_control
	import tic_pkg::*;
#(
	parameter int NCH = TIC_CHANNELS
) (
	input  wire logic                     clk_sys,
	input  wire logic                     reset,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [TIC_ADR_WIDTH-1:0] wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic [NCH-1:0][15:0]     channelCounter,
	input  wire logic [NCH-1:0]           counterTick,
	input  wire logic [NCH-1:0]           countDown,
	input  wire logic                     phaseCountSelect,
	input  wire logic [1:0]               combinedMode,
	input  wire logic                     standby,
	input  wire logic [NCH-1:0]           dmaAck,
	input  wire logic [NCH-1:0]           pinAIn,
	output logic      [NCH-1:0]           pinAOut,
	output logic      [NCH-1:0]           pinAOe,
	input  wire logic [NCH-1:0]           pinBIn,
	output logic      [NCH-1:0]           pinBOut,
	output logic      [NCH-1:0]           pinBOe,
	output logic      [NCH-1:0]           wrapIrq,
	output logic      [NCH-1:0]           matchAIrq,
	output logic      [NCH-1:0]           matchBIrq
);

	typedef struct packed {
		tic_chan_type [NCH-1:0] ch;
		logic                   ack;
		logic [31:0]            rdData;
	} tic_state_type;

	tic_state_type stateReg;
	tic_state_type stateNext;

	// One general register step: compare output or capture for one field.
	function automatic tic_gr_result_type grStep(
		input logic [2:0] field,
		input logic       eqRise,
		input logic       inRise,
		input logic       inFall,
		input logic       pinCur,
		input logic       noToggle,
		input logic       ignoreSel
	);
		tic_gr_result_type res;
		res.hit = 1'b0;
		res.capture = 1'b0;
		res.pin = pinCur;
		if (ignoreSel) begin
			// Registers act as plain compare registers; the pins belong
			// to the PWM logic, so nothing is driven from here.
			res.hit = eqRise;
		end else if (!field[2]) begin
			res.hit = eqRise;
			if (eqRise) begin
				unique case (field[1:0])
					OUT_NONE:   res.pin = pinCur;
					OUT_LOW:    res.pin = 1'b0;
					OUT_HIGH:   res.pin = 1'b1;
					OUT_TOGGLE: res.pin = noToggle | ~pinCur;
				endcase
			end
		end else begin
			unique case (field[1:0])
				CAP_RISE: res.capture = inRise;
				CAP_FALL: res.capture = inFall;
				CAP_BOTH: res.capture = inRise | inFall;
				CAP_NONE: res.capture = 1'b0;
			endcase
			res.hit = res.capture;
		end
		return res;
	endfunction

	logic                   take;
	logic [2:0]             chSel;
	logic [4:0]             regSel;
	logic [31:0]            rd;
	logic                   ignoreSel;
	logic                   downOk;
	logic                   wrap;
	logic                   eqA;
	logic                   eqB;
	logic [2:0]             setV;
	logic [2:0]             clrV;
	tic_gr_result_type      resA;
	tic_gr_result_type      resB;

	always_comb begin
		stateNext = stateReg;
		take = wb_cyc_i & wb_stb_i & ~stateReg.ack;
		chSel = wb_adr_i[7:5];
		regSel = wb_adr_i[4:0];
		rd = '0;
		ignoreSel = 1'b0;
		downOk = 1'b0;
		wrap = 1'b0;
		eqA = 1'b0;
		eqB = 1'b0;
		setV = '0;
		clrV = '0;
		resA = '0;
		resB = '0;
		for (int c = 0; c < NCH; c++) begin
			// Two stages synchronise the pins, the third keeps the last
			// level for edge detection.
			stateNext.ch[c].syncA = {stateReg.ch[c].syncA[1:0], pinAIn[c]};
			stateNext.ch[c].syncB = {stateReg.ch[c].syncB[1:0], pinBIn[c]};

			ignoreSel = (c == CH_PWM_LO || c == CH_PWM_HI) &&
				(combinedMode == CMD_COMPLEMENTARY ||
				combinedMode == CMD_RESET_SYNC);

			// A match is taken once, when equality first appears, so a
			// stopped counter does not keep re-triggering the flag.
			eqA = channelCounter[c] == stateReg.ch[c].genA;
			eqB = channelCounter[c] == stateReg.ch[c].genB;
			stateNext.ch[c].eqA = eqA;
			stateNext.ch[c].eqB = eqB;

			resA = grStep(stateReg.ch[c].fieldA,
				eqA & ~stateReg.ch[c].eqA,
				stateReg.ch[c].syncA[1] & ~stateReg.ch[c].syncA[2],
				~stateReg.ch[c].syncA[1] & stateReg.ch[c].syncA[2],
				stateReg.ch[c].pinA, c == CH_NO_TOGGLE,
				ignoreSel);
			resB = grStep(stateReg.ch[c].fieldB,
				eqB & ~stateReg.ch[c].eqB,
				stateReg.ch[c].syncB[1] & ~stateReg.ch[c].syncB[2],
				~stateReg.ch[c].syncB[1] & stateReg.ch[c].syncB[2],
				stateReg.ch[c].pinB, c == CH_NO_TOGGLE,
				ignoreSel);
			stateNext.ch[c].pinA = resA.pin;
			stateNext.ch[c].pinB = resB.pin;

			downOk = (c == CH_PHASE && phaseCountSelect) ||
				((c == CH_PWM_LO || c == CH_PWM_HI) &&
				combinedMode == CMD_COMPLEMENTARY);
			if (countDown[c] && downOk) begin
				wrap = counterTick[c] &&
					channelCounter[c] == CNT_ZERO;
			end else begin
				wrap = counterTick[c] &&
					channelCounter[c] == CNT_ALL_ONES;
			end

			setV = '0;
			setV[FLAG_WRAP] = wrap;
			setV[FLAG_B] = resB.hit;
			setV[FLAG_A] = resA.hit;
			clrV = '0;

			if (take && int'(chSel) == c) begin
				unique case (regSel)
					OFF_IO_SEL: begin
						rd[7:0] = IO_SEL_RESET |
							{1'b0, stateReg.ch[c].fieldB, 1'b0,
							stateReg.ch[c].fieldA};
						if (wb_we_i && wb_sel_i[0]) begin
							stateNext.ch[c].fieldB =
								wb_dat_i[IO_B_LSB+:3];
							stateNext.ch[c].fieldA =
								wb_dat_i[IO_A_LSB+:3];
						end
					end
					OFF_FLAGS: begin
						rd[7:0] = FLAGS_RESET |
							{5'h00, stateReg.ch[c].flags};
						if (wb_we_i) begin
							if (wb_sel_i[0]) begin
								clrV = stateReg.ch[c].armed &
									~wb_dat_i[2:0];
							end
							stateNext.ch[c].armed = '0;
						end else begin
							stateNext.ch[c].armed =
								stateReg.ch[c].flags;
						end
					end
					OFF_IRQ_EN: begin
						rd[7:0] = IRQ_EN_RESET |
							{5'h00, stateReg.ch[c].irqEn};
						if (wb_we_i && wb_sel_i[0]) begin
							stateNext.ch[c].irqEn = wb_dat_i[2:0];
						end
					end
					OFF_GEN_A: begin
						rd[15:0] = stateReg.ch[c].genA;
						if (wb_we_i && wb_sel_i[0]) begin
							stateNext.ch[c].genA[7:0] = wb_dat_i[7:0];
						end
						if (wb_we_i && wb_sel_i[1]) begin
							stateNext.ch[c].genA[15:8] = wb_dat_i[15:8];
						end
					end
					OFF_GEN_B: begin
						rd[15:0] = stateReg.ch[c].genB;
						if (wb_we_i && wb_sel_i[0]) begin
							stateNext.ch[c].genB[7:0] = wb_dat_i[7:0];
						end
						if (wb_we_i && wb_sel_i[1]) begin
							stateNext.ch[c].genB[15:8] = wb_dat_i[15:8];
						end
					end
					default: rd = '0;
				endcase
			end

			if (dmaAck[c] && c <= CH_DMA_LAST) begin
				clrV[FLAG_A] = 1'b1;
			end
			// Hardware events win over a write or transfer clear in the same cycle.
			stateNext.ch[c].flags =
				(stateReg.ch[c].flags & ~clrV) | setV;

			// A capture overrides a software write in the same cycle.
			if (resA.capture) begin
				stateNext.ch[c].genA = channelCounter[c];
			end
			if (resB.capture) begin
				stateNext.ch[c].genB = channelCounter[c];
			end

			if (standby) begin
				stateNext.ch[c].fieldA = '0;
				stateNext.ch[c].fieldB = '0;
				stateNext.ch[c].flags = '0;
				stateNext.ch[c].armed = '0;
				stateNext.ch[c].irqEn = '0;
				stateNext.ch[c].pinA = 1'b0;
				stateNext.ch[c].pinB = 1'b0;
			end
		end

		stateNext.ack = take;
		if (take && !wb_we_i) begin
			stateNext.rdData = rd;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			stateReg <= '0;
		end else begin
			stateReg <= stateNext;
		end
	end

	always_comb begin
		wb_dat_o = stateReg.rdData;
		wb_ack_o = stateReg.ack;
		for (int c = 0; c < NCH; c++) begin
			pinAOut[c] = stateReg.ch[c].pinA;
			pinBOut[c] = stateReg.ch[c].pinB;
			pinAOe[c] = ~stateNext.ch[c].fieldA[2] &
				(stateReg.ch[c].fieldA[1:0] != OUT_NONE) &
				~((c == CH_PWM_LO || c == CH_PWM_HI) &&
				combinedMode[1]);
			pinBOe[c] = ~stateReg.ch[c].fieldB[2] &
				(stateReg.ch[c].fieldB[1:0] != OUT_NONE) &
				~((c == CH_PWM_LO || c == CH_PWM_HI) &&
				combinedMode[1]);
			wrapIrq[c] = stateReg.ch[c].flags[FLAG_WRAP] &
				stateReg.ch[c].irqEn[FLAG_WRAP];
			matchBIrq[c] = stateReg.ch[c].flags[FLAG_B] &
				stateReg.ch[c].irqEn[FLAG_B];
			matchAIrq[c] = stateReg.ch[c].flags[FLAG_A] &
				stateReg.ch[c].irqEn[FLAG_A];
		end
	end

endmodule

// file: verif/tic_io_properties.sv
`timescale 1ns/1ps
module tic_io_properties
	import tic_pkg::*;
#(
	parameter int NCH = TIC_CHANNELS
) (
	input wire logic                     clk_sys,
	input wire logic                     reset,
	input wire logic                     wb_cyc_i,
	input wire logic                     wb_stb_i,
	input wire logic                     wb_we_i,
	input wire logic [TIC_ADR_WIDTH-1:0] wb_adr_i,
	input wire logic [31:0]              wb_dat_o,
	input wire logic                     wb_ack_o,
	input wire logic [1:0]               combinedMode,
	input wire logic                     standby,
	input wire logic [NCH-1:0]           pinAOe,
	input wire logic [NCH-1:0]           pinBOe,
	input wire logic [NCH-1:0]           wrapIrq,
	input wire logic [NCH-1:0]           matchBIrq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_answer_a: assert property (take |=> wb_ack_o)
		else $error("request not acked in the next cycle");
	read_hold_a: assert property (!(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o))
		else $error("read data moved outside a read ack");
	unmapped_zero_a: assert property (take && !wb_we_i && wb_adr_i[7:5] > 3'h4
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	pwm_pins_off_a: assert property (combinedMode[1] && $past(combinedMode[1])
		|-> pinAOe[4:3] == 2'h0 && pinBOe[4:3] == 2'h0)
		else $error("pwm channel pin driven");
	wrap_sticky_a: assert property (wrapIrq[1] && !(take && wb_we_i) && !standby
		|=> wrapIrq[1]) else $error("wrap request lost");
	match_sticky_a: assert property (matchBIrq[0] && !(take && wb_we_i)
		&& !standby |=> matchBIrq[0]) else $error("match lost");
	standby_clear_a: assert property (standby |=> wrapIrq == '0
		&& matchBIrq == '0) else $error("request left after standby");
endmodule

bind tic_timer_io_control tic_io_properties #(.NCH(NCH)) chk_u (
	.clk_sys, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .combinedMode, .standby, .pinAOe, .pinBOe, .wrapIrq,
	.matchBIrq
);

// file: verif/tic_cpu_model.sv
`timescale 1ns/1ps
module tic_cpu_model
	import tic_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        wb_ack_o,
	input  wire logic [31:0] wb_dat_o,
	output logic             wbCyc,
	output logic             wbStb,
	output logic             wbWe,
	output logic [7:0]       wbAdr,
	output logic [3:0]       wbSel,
	output logic [31:0]      wbDat
);
	initial begin
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDat} = '0;
	end
	// Ack and read data are sampled at the rising edge, before the
	// registered slave updates them in that same time step.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDat <= d;
		wbSel <= (a[4:0] >= OFF_GEN_A) ? 4'h3 : 4'h1;
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbDat <= ~d;
		wbAdr <= ~a;
	endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench
	import tic_pkg::*;
;
	logic             clk_sys = 1'b0;
	logic             reset = 1'b1;
	logic [4:0][15:0] cntV = {5{16'h0100}};
	logic [4:0]       tick = '0, down = '0, dma = '0, pinA = '0, pinB = '0;
	logic             phase = 1'b0, standby = 1'b0;
	logic [1:0]       cmode = 2'h0;
	logic             cyc, stb, we, ack;
	logic [7:0]       adr;
	logic [3:0]       sel;
	logic [31:0]      datW, datR;
	logic [4:0]       aOut, aOe, bOut, bOe, wIrq, maIrq, mbIrq;
	int               err_count = 0, checks_done = 0, cycles = 0;
	tic_timer_io_control dut_u (
		.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
		.wb_dat_o(datR), .wb_ack_o(ack), .channelCounter(cntV),
		.counterTick(tick), .countDown(down), .phaseCountSelect(phase),
		.combinedMode(cmode), .standby(standby), .dmaAck(dma),
		.pinAIn(pinA), .pinAOut(aOut), .pinAOe(aOe), .pinBIn(pinB),
		.pinBOut(bOut), .pinBOe(bOe), .wrapIrq(wIrq), .matchAIrq(maIrq),
		.matchBIrq(mbIrq)
	);
	tic_cpu_model cpu_u (
		.clk_sys(clk_sys), .wb_ack_o(ack), .wb_dat_o(datR), .wbCyc(cyc),
		.wbStb(stb), .wbWe(we), .wbAdr(adr), .wbSel(sel), .wbDat(datW)
	);
	initial forever #10 clk_sys = ~clk_sys;
	function automatic logic [7:0] ad(input int c, input logic [4:0] o);
		return {c[2:0], o};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
		logic [31:0] q;
		cpu_u.xfer(1'b0, a, 32'h0, q);
		chk(n, e, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		cpu_u.xfer(1'b1, a, d, q);
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic finish_test;
		$display("Mismatches %0d, checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic t_reset;
		for (int c = 0; c < 5; c++) begin
			rd(ad(c, OFF_IO_SEL), 32'h08, "io_sel");
			rd(ad(c, OFF_FLAGS), 32'h78, "flags");
			rd(ad(c, OFF_IRQ_EN), 32'h78, "irq_en");
		end
		wr(ad(1, OFF_IO_SEL), 32'hff);
		rd(ad(1, OFF_IO_SEL), 32'h7f, "io_sel_all");
		rd(ad(0, OFF_IO_SEL), 32'h08, "io_sel_other");
		rd(8'ha0, 32'h0, "unmapped");
	endtask
	task automatic t_compare;
		wr(ad(0, OFF_GEN_A), 32'h10);
		wr(ad(0, OFF_GEN_B), 32'h10);
		wr(ad(0, OFF_IO_SEL), 32'h2b);
		wt(1);
		chk("pinA0_idle", 1'b0, aOut[0]);
		@(posedge clk_sys) cntV[0] <= 16'h0010;
		wt(3);
		chk("pinA0_match", 1'b1, aOut[0]);
		chk("pinB0_match", 1'b1, bOut[0]);
		@(posedge clk_sys) cntV[0] <= 16'h0011;
		@(posedge clk_sys) cntV[0] <= 16'h0010;
		wt(3);
		chk("pinA0_toggle", 1'b0, aOut[0]);
		wr(ad(0, OFF_IRQ_EN), 32'h7b);
		wt(1);
		chk("irqA0", 1'b1, maIrq[0]);
		@(posedge clk_sys) dma[0] <= 1'b1;
		@(posedge clk_sys) dma[0] <= 1'b0;
		wt(1);
		chk("irqA0_dma", 1'b0, maIrq[0]);
		chk("irqB0", 1'b1, mbIrq[0]);
		// A fresh match on A lands in the same cycle as a transfer clear.
		wr(ad(0, OFF_IO_SEL), 32'h1b);
		@(posedge clk_sys) cntV[0] <= 16'h0011;
		@(posedge clk_sys) {cntV[0], dma[0]} <= {16'h0010, 1'b1};
		@(posedge clk_sys) dma[0] <= 1'b0;
		wt(1);
		chk("irqA0_set_wins", 1'b1, maIrq[0]);
		chk("pinB0_low", 1'b0, bOut[0]);
		wr(ad(0, OFF_FLAGS), 32'h78);
		rd(ad(0, OFF_FLAGS), 32'h7b, "flags_unread");
		wr(ad(0, OFF_FLAGS), 32'h78);
		rd(ad(0, OFF_FLAGS), 32'h78, "flags_clear");
		wr(ad(0, OFF_FLAGS), 32'h7f);
		rd(ad(0, OFF_FLAGS), 32'h78, "flags_no_set");
		wr(ad(2, OFF_GEN_A), 32'h5);
		wr(ad(2, OFF_IO_SEL), 32'h0b);
		@(posedge clk_sys) cntV[2] <= 16'h0005;
		wt(3);
		chk("pinA2_match", 1'b1, aOut[2]);
		@(posedge clk_sys) cntV[2] <= 16'h0006;
		@(posedge clk_sys) cntV[2] <= 16'h0005;
		wt(3);
		chk("pinA2_again", 1'b1, aOut[2]);
	endtask
	task automatic t_capture;
		// Channel 1 still holds code 11 in both fields here.
		@(posedge clk_sys) pinA[1] <= 1'b1;
		wt(5);
		chk("pinA1_oe", 1'b0, aOe[1]);
		rd(ad(1, OFF_FLAGS), 32'h78, "cap_none");
		rd(ad(1, OFF_GEN_A), 32'h0, "cap_none_gr");
		@(posedge clk_sys) pinA[1] <= 1'b0;
		wr(ad(1, OFF_IO_SEL), 32'h6c);
		@(posedge clk_sys) {cntV[1], pinA[1], pinB[1]} <= {16'h1234, 2'h3};
		wt(5);
		@(posedge clk_sys) {cntV[1], pinA[1], pinB[1]} <= {16'h5678, 2'h0};
		wt(5);
		rd(ad(1, OFF_GEN_A), 32'h1234, "capA_rise");
		rd(ad(1, OFF_GEN_B), 32'h5678, "capB_both");
		rd(ad(1, OFF_FLAGS), 32'h7b, "cap_flags");
	endtask
	// Channel 2 counts down onto its register B value of zero, so its
	// compare flag B rises along with the wrap flag.
	task automatic t_wrap;
		wr(ad(1, OFF_IRQ_EN), 32'h7c);
		@(posedge clk_sys) begin
			{cntV[1], cntV[0], cntV[2]} <= {16'hffff, 32'h0};
			{tick, down, phase} <= {5'h07, 5'h05, 1'b1};
		end
		@(posedge clk_sys) tick <= 5'h00;
		wt(2);
		chk("wrap_irq1", 1'b1, wIrq[1]);
		rd(ad(0, OFF_FLAGS), 32'h78, "wrap_down0");
		rd(ad(2, OFF_FLAGS), 32'h7f, "wrap_down2");
	endtask
	task automatic t_pwm;
		@(posedge clk_sys) cmode <= 2'h2;
		wr(ad(3, OFF_IO_SEL), 32'h2a);
		wt(1);
		chk("pinB3_pwm", 1'b0, bOe[3]);
		@(posedge clk_sys) cmode <= 2'h0;
		wt(2);
		chk("pinB3_plain", 1'b1, bOe[3]);
		@(posedge clk_sys) standby <= 1'b1;
		@(posedge clk_sys) standby <= 1'b0;
		rd(ad(3, OFF_IO_SEL), 32'h08, "sby_io");
		rd(ad(1, OFF_FLAGS), 32'h78, "sby_flags");
		rd(ad(1, OFF_IRQ_EN), 32'h78, "sby_en");
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_compare();
		t_capture();
		t_wrap();
		t_pwm();
		finish_test();
	end
endmodule
